// >>> core/sxra_consts.svh
// Constants for the shared packed/stack register file
`ifndef SXRA_CONSTS_SVH
`define SXRA_CONSTS_SVH
`define SXRA_NUM_NARROW      8
`define SXRA_NARROW_W        64
`define SXRA_NUM_WIDE        8
`define SXRA_WIDE_W          128
`define SXRA_STACK_W         80
`define SXRA_TAG_RESET       8'h00
`define SXRA_TAG_ALL_VALID   8'hff
`define SXRA_WIDE_ALIGN_BITS 4
`endif

// >>> core/sxra_pkg.sv
// Types for the shared packed/stack register file
package sxra_pkg;
    typedef enum logic [2:0] {
        SXRA_OP_NONE,
        SXRA_OP_NARROW_WR,
        SXRA_OP_NARROW_RD,
        SXRA_OP_STACK_WR,
        SXRA_OP_STACK_RD,
        SXRA_OP_EMPTY,
        SXRA_OP_TAG_WR
    } sxra_op_type;
    typedef enum logic [1:0] {
        SXRA_MEM_NONE,
        SXRA_MEM_NARROW,
        SXRA_MEM_WIDE,
        SXRA_MEM_WIDE_UNALIGNED
    } sxra_mem_type;
endpackage : sxra_pkg

// >>> core/sxra_wide_regs.sv
// Separate 128-bit packed register bank
`timescale 1ns/1ps
`include "sxra_consts.svh"
module sxra_wide_regs #(
    parameter int NUM   = `SXRA_NUM_WIDE,
    parameter int WIDTH = `SXRA_WIDE_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(NUM)-1:0]   wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(NUM)-1:0]   rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);
    // Refuse sizes that leave the index port without bits
    if (NUM < 2 || WIDTH < 1) begin : g_bad_size
        $error("sxra_wide_regs: bad size");
    end
    logic [WIDTH-1:0] bank [NUM];
    // Never touched by stack or tag activity
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM; i++) bank[i] <= '0;
        end else if (wr_en) begin
            bank[wr_idx] <= wr_data;
        end
    end
    // Contents are raw bits; any data type reads back the same
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= bank[rd_idx];
        end
    end
endmodule : sxra_wide_regs

// >>> core/sxra_regfile.sv
// Shared packed/stack register file with tag word and alignment checks
// Summary of operation
// - Narrow packed regs alias the stack registers.
// - Narrow register reference sets all tag bits.
// - Empty-state instruction clears all tag bits.
// - Wide registers stored apart from stack.
// - Misaligned wide access faults unless unaligned move.
// - Misaligned narrow access never faults.
// - Stack op with full tag flags overflow.
// - Wide data independent of instruction data type.
`timescale 1ns/1ps
`include "sxra_consts.svh"
module sxra_regfile #(
    parameter int NUM     = `SXRA_NUM_NARROW,
    parameter int NWIDTH  = `SXRA_NARROW_W,
    parameter int SWIDTH  = `SXRA_STACK_W,
    parameter int WWIDTH  = `SXRA_WIDE_W,
    parameter int AWIDTH  = 32
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire sxra_pkg::sxra_op_type    op,
    input  wire logic [$clog2(NUM)-1:0]   idx,
    input  wire logic [SWIDTH-1:0]        wr_data,
    input  wire logic [NUM-1:0]           tag_wr_data,
    output logic      [SWIDTH-1:0]        rd_data,
    output logic      [NUM-1:0]           tag_valid,
    output logic                          stack_overflow,
    input  wire logic                     wide_wr_en,
    input  wire logic [$clog2(NUM)-1:0]   wide_wr_idx,
    input  wire logic [WWIDTH-1:0]        wide_wr_data,
    input  wire logic [$clog2(NUM)-1:0]   wide_rd_idx,
    output logic      [WWIDTH-1:0]        wide_rd_data,
    input  wire sxra_pkg::sxra_mem_type   mem_kind,
    input  wire logic [AWIDTH-1:0]        mem_addr,
    output logic                          align_fault
);
    localparam int EXTW       = SWIDTH - NWIDTH;
    localparam int ALIGN      = `SXRA_WIDE_ALIGN_BITS;
    localparam int WIDE_BYTES = WWIDTH / 8;

    // Refuse sizes that the tag word and the alias view cannot serve
    if (NUM != 8) begin : g_bad_num
        $error("sxra_regfile: tag word needs eight registers");
    end
    if (SWIDTH <= NWIDTH) begin : g_bad_swidth
        $error("sxra_regfile: stack entry must be wider than packed view");
    end
    if (AWIDTH <= ALIGN) begin : g_bad_awidth
        $error("sxra_regfile: address narrower than alignment field");
    end
    if (WIDE_BYTES != (1 << ALIGN)) begin : g_bad_align
        $error("sxra_regfile: alignment field does not match wide register size");
    end

    // Shared storage: narrow view is the low bits of each stack entry
    logic [SWIDTH-1:0] shared [NUM];
    logic              narrow_ref;
    logic              stack_ref;
    logic              write_ref;
    logic              read_ref;
    logic [SWIDTH-1:0] write_value;
    logic [SWIDTH-1:0] read_value;

    // Memory reference classes and tag state checks
    logic              wide_ref;
    logic              wide_fault;
    logic              overflow_hit;

    // Op classes, shared by storage, read and overflow logic
    function automatic logic is_narrow_op(input sxra_pkg::sxra_op_type o);
        is_narrow_op = (o == sxra_pkg::SXRA_OP_NARROW_WR) || (o == sxra_pkg::SXRA_OP_NARROW_RD);
    endfunction : is_narrow_op

    function automatic logic is_stack_op(input sxra_pkg::sxra_op_type o);
        is_stack_op = (o == sxra_pkg::SXRA_OP_STACK_WR) || (o == sxra_pkg::SXRA_OP_STACK_RD);
    endfunction : is_stack_op

    function automatic logic is_write_op(input sxra_pkg::sxra_op_type o);
        is_write_op = (o == sxra_pkg::SXRA_OP_NARROW_WR) || (o == sxra_pkg::SXRA_OP_STACK_WR);
    endfunction : is_write_op

    function automatic logic is_read_op(input sxra_pkg::sxra_op_type o);
        is_read_op = (o == sxra_pkg::SXRA_OP_NARROW_RD) || (o == sxra_pkg::SXRA_OP_STACK_RD);
    endfunction : is_read_op

    // Stack form of a narrow value: the top field is forced to ones
    function automatic logic [SWIDTH-1:0] narrow_to_stack(input logic [NWIDTH-1:0] v);
        narrow_to_stack = {{EXTW{1'b1}}, v};
    endfunction : narrow_to_stack

    // Narrow view of a stack entry, zero extended for the shared read port
    function automatic logic [SWIDTH-1:0] stack_to_narrow(input logic [SWIDTH-1:0] e);
        stack_to_narrow = {{EXTW{1'b0}}, e[NWIDTH-1:0]};
    endfunction : stack_to_narrow

    // Any set bit below the wide register's byte size is a misaligned start
    function automatic logic wide_misaligned(input logic [AWIDTH-1:0] a);
        wide_misaligned = |a[ALIGN-1:0];
    endfunction : wide_misaligned

    function automatic logic tag_full(input logic [NUM-1:0] t);
        tag_full = (t == `SXRA_TAG_ALL_VALID);
    endfunction : tag_full

    // Tag word with one more entry marked as holding a value
    function automatic logic [NUM-1:0] tag_set_bit(input logic [NUM-1:0] t, input logic [$clog2(NUM)-1:0] i);
        tag_set_bit    = t;
        tag_set_bit[i] = 1'b1;
    endfunction : tag_set_bit

    assign narrow_ref = is_narrow_op(op);
    assign stack_ref  = is_stack_op(op);
    assign write_ref  = is_write_op(op);
    assign read_ref   = is_read_op(op);

    // Unaligned move kind is left out on purpose: it completes without fault
    assign wide_ref   = (mem_kind == sxra_pkg::SXRA_MEM_WIDE);
    assign wide_fault = wide_ref && wide_misaligned(mem_addr);

    // Judged on the tag word before this op; a missed empty step shows here
    assign overflow_hit = stack_ref && tag_full(tag_valid);

    // Write value in stack form, whichever view the op uses
    always_comb begin
        if (narrow_ref) begin
            write_value = narrow_to_stack(wr_data[NWIDTH-1:0]);
        end else begin
            write_value = wr_data;
        end
    end

    // Read value in the view the op asks for
    always_comb begin
        if (narrow_ref) begin
            read_value = stack_to_narrow(shared[idx]);
        end else begin
            read_value = shared[idx];
        end
    end

    // Narrow writes land in the same entries that stack writes use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM; i++) begin
                shared[i] <= '0;
            end
        end else if (write_ref) begin
            shared[idx] <= write_value;
        end
    end

    // Last read result stands until the next read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else if (read_ref) begin
            rd_data <= read_value;
        end else begin
            rd_data <= rd_data;
        end
    end

    // Tag word: one valid bit per shared register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tag_valid <= `SXRA_TAG_RESET;
        end else begin
            case (op)
                sxra_pkg::SXRA_OP_NARROW_WR,
                sxra_pkg::SXRA_OP_NARROW_RD: begin
                    tag_valid <= `SXRA_TAG_ALL_VALID;
                end
                sxra_pkg::SXRA_OP_EMPTY: begin
                    tag_valid <= `SXRA_TAG_RESET;
                end
                sxra_pkg::SXRA_OP_TAG_WR: begin
                    tag_valid <= tag_wr_data;
                end
                sxra_pkg::SXRA_OP_STACK_WR: begin
                    tag_valid <= tag_set_bit(tag_valid, idx);
                end
                default: begin
                    tag_valid <= tag_valid;
                end
            endcase
        end
    end

    // One cycle of overflow per offending stack op
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stack_overflow <= 1'b0;
        end else begin
            stack_overflow <= overflow_hit;
        end
    end

    // Narrow misalignment only costs latency, so it never faults
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            align_fault <= 1'b0;
        end else begin
            align_fault <= wide_fault;
        end
    end

    // Wide bank sits apart: stack, narrow and tag traffic never reach it
    sxra_wide_regs #(
        .NUM   (NUM),
        .WIDTH (WWIDTH)
    ) u_wide (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (wide_wr_en),
        .wr_idx   (wide_wr_idx),
        .wr_data  (wide_wr_data),
        .rd_idx   (wide_rd_idx),
        .rd_data  (wide_rd_data)
    );
endmodule : sxra_regfile

// >>> sim/sxra_pipe_model.sv
// Pipeline model issuing register references
`timescale 1ns/1ps
module sxra_pipe_model (
    input wire logic core_clk,
    output sxra_pkg::sxra_op_type op,
    output logic [2:0] idx,
    output logic [79:0] wr_data,
    output logic [7:0] tag_wr_data,
    output sxra_pkg::sxra_mem_type mem_kind,
    output logic [31:0] mem_addr
);
    initial begin
        op          = sxra_pkg::SXRA_OP_NONE;
        idx         = 3'h0;
        wr_data     = 80'h0;
        tag_wr_data = 8'h0;
        mem_kind    = sxra_pkg::SXRA_MEM_NONE;
        mem_addr    = 32'h0;
    end
    // One reference per cycle, launched at the falling edge
    task automatic issue(input sxra_pkg::sxra_op_type o, input logic [2:0] i, input logic [79:0] d);
        @(negedge core_clk);
        op          = o;
        idx         = i;
        wr_data     = d;
        tag_wr_data = d[7:0];
    endtask : issue
    task automatic access(input sxra_pkg::sxra_mem_type k, input logic [31:0] a);
        @(negedge core_clk);
        mem_kind = k;
        mem_addr = a;
    endtask : access
endmodule : sxra_pipe_model

// >>> sim/sxra_regfile_asserts.sv
// Checker for tag word, overflow and alignment faults
`timescale 1ns/1ps
module sxra_regfile_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire sxra_pkg::sxra_op_type op,
    input wire logic [7:0] tag_wr_data,
    input wire logic [7:0] tag_valid,
    input wire logic stack_overflow,
    input wire sxra_pkg::sxra_mem_type mem_kind,
    input wire logic [31:0] mem_addr,
    input wire logic align_fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire stk = op inside {sxra_pkg::SXRA_OP_STACK_WR, sxra_pkg::SXRA_OP_STACK_RD};
    wire nar = op inside {sxra_pkg::SXRA_OP_NARROW_WR, sxra_pkg::SXRA_OP_NARROW_RD};
    wire mis = mem_kind == sxra_pkg::SXRA_MEM_WIDE && mem_addr[3:0] != 4'h0;
    chk_narrow_tag: assert property (nar |=> tag_valid == 8'hff) else $error("tag not full");
    chk_empty_tag: assert property (op == sxra_pkg::SXRA_OP_EMPTY |=> tag_valid == 8'h00)
        else $error("tag not cleared");
    chk_over_raise: assert property (stk && tag_valid == 8'hff |=> stack_overflow) else $error("no overflow");
    chk_over_cause: assert property (stack_overflow |-> $past(stk && tag_valid == 8'hff))
        else $error("stray overflow");
    chk_fault_raise: assert property (mis |=> align_fault) else $error("no fault");
    chk_fault_cause: assert property (align_fault |-> $past(mis)) else $error("stray fault");
    chk_tag_load: assert property (op == sxra_pkg::SXRA_OP_TAG_WR |=> tag_valid == $past(tag_wr_data))
        else $error("tag not loaded");
    chk_tag_hold: assert property (op == sxra_pkg::SXRA_OP_NONE |=> $stable(tag_valid))
        else $error("tag moved");
    cover property (stk && tag_valid == 8'hff);
    cover property (mis);
    cover property (op == sxra_pkg::SXRA_OP_EMPTY);
endmodule : sxra_regfile_chk
bind sxra_regfile sxra_regfile_chk chk_u (.core_clk(core_clk), .rst(rst), .op(op), .tag_wr_data(tag_wr_data),
    .tag_valid(tag_valid), .stack_overflow(stack_overflow), .mem_kind(mem_kind), .mem_addr(mem_addr),
    .align_fault(align_fault));

// >>> sim/sxra_regfile_test.sv
// Self-checking bench for the shared register file
`timescale 1ns/1ps
module sxra_regfile_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wen = 1'b0;
    logic [2:0] widx = 3'h3;
    logic [127:0] wdat = 128'h0;
    logic [127:0] wrd;
    sxra_pkg::sxra_op_type op;
    sxra_pkg::sxra_mem_type mem_kind;
    logic [2:0] idx;
    logic [79:0] wr_data, rd_data;
    logic [7:0] twd, tag;
    logic [31:0] addr;
    logic ovf, flt;
    int n_errors = 0;
    int num_checks = 0;
    always #4 core_clk = ~core_clk;
    sxra_pipe_model pl_u (.core_clk(core_clk), .op(op), .idx(idx), .wr_data(wr_data), .tag_wr_data(twd),
        .mem_kind(mem_kind), .mem_addr(addr));
    sxra_regfile dut_u (.core_clk(core_clk), .rst(rst), .op(op), .idx(idx), .wr_data(wr_data), .tag_wr_data(twd),
        .rd_data(rd_data), .tag_valid(tag), .stack_overflow(ovf), .wide_wr_en(wen), .wide_wr_idx(widx),
        .wide_wr_data(wdat), .wide_rd_idx(widx), .wide_rd_data(wrd), .mem_kind(mem_kind), .mem_addr(addr),
        .align_fault(flt));
    task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: data %h want %h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_tag(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: tag %h want %h", $time, got, exp);
        end
    endtask : chk_tag
    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk_flag
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic t_alias;
        pl_u.issue(sxra_pkg::SXRA_OP_NARROW_WR, 3'h2, 80'h5a5a_0123_4567_89ab_cdef);
        pl_u.issue(sxra_pkg::SXRA_OP_STACK_RD, 3'h2, 80'h0);
        chk_tag(tag, 8'hff);
        pl_u.issue(sxra_pkg::SXRA_OP_EMPTY, 3'h0, 80'h0);
        chk_flag(ovf, 1'b1);
        chk_data({48'h0, rd_data}, 128'hffff_0123_4567_89ab_cdef);
        pl_u.issue(sxra_pkg::SXRA_OP_STACK_WR, 3'h5, 80'h7777_1111_2222_3333_4444);
        chk_tag(tag, 8'h00);
        pl_u.issue(sxra_pkg::SXRA_OP_NARROW_RD, 3'h5, 80'h0);
        chk_flag(ovf, 1'b0);
        chk_tag(tag, 8'h20);
        pl_u.issue(sxra_pkg::SXRA_OP_TAG_WR, 3'h0, 80'h3c);
        chk_data({48'h0, rd_data}, 128'h1111_2222_3333_4444);
        chk_tag(tag, 8'hff);
        pl_u.issue(sxra_pkg::SXRA_OP_NONE, 3'h0, 80'h0);
        chk_tag(tag, 8'h3c);
    endtask : t_alias
    task automatic t_wide;
        // Wide write between a stack write and a stack read of the same index, then a narrow write
        pl_u.issue(sxra_pkg::SXRA_OP_STACK_WR, 3'h3, 80'h1234);
        pl_u.issue(sxra_pkg::SXRA_OP_NONE, 3'h0, 80'h0);
        {wen, wdat} = {1'b1, 128'hc3};
        pl_u.issue(sxra_pkg::SXRA_OP_STACK_RD, 3'h3, 80'h0);
        wen = 1'b0;
        pl_u.issue(sxra_pkg::SXRA_OP_NARROW_WR, 3'h3, 80'h9);
        chk_data({48'h0, rd_data}, 128'h1234);
        pl_u.issue(sxra_pkg::SXRA_OP_NONE, 3'h0, 80'h0);
        pl_u.issue(sxra_pkg::SXRA_OP_NONE, 3'h0, 80'h0);
        chk_data(wrd, 128'hc3);
        chk_tag(tag, 8'hff);
    endtask : t_wide
    task automatic t_align(input sxra_pkg::sxra_mem_type k, input logic [31:0] a, input logic e);
        pl_u.access(k, a);
        pl_u.access(sxra_pkg::SXRA_MEM_NONE, 32'h0);
        chk_flag(flt, e);
    endtask : t_align
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        t_alias;
        t_wide;
        t_align(sxra_pkg::SXRA_MEM_WIDE, 32'h108, 1'b1);
        t_align(sxra_pkg::SXRA_MEM_WIDE, 32'h110, 1'b0);
        t_align(sxra_pkg::SXRA_MEM_WIDE_UNALIGNED, 32'h101, 1'b0);
        t_align(sxra_pkg::SXRA_MEM_NARROW, 32'h3f, 1'b0);
        give_verdict;
    end
    initial begin
        #20000;
        n_errors++;
        give_verdict;
    end
endmodule : sxra_regfile_test
